// ---- design/fifo_flags_params.svh ----
/*
 * Constants of the dual-clock fifo flag block: register offsets, depths,
 * default offsets, and field positions of the status register.
 * Assumes inclusion by bare name from the package or module that needs it.
 */
`ifndef FIFO_FLAGS_PARAMS_SVH
`define FIFO_FLAGS_PARAMS_SVH

`define REG_STATUS      32'h0000_0000
`define REG_CONTROL     32'h0000_0004
`define REG_OFFSETS     32'h0000_0008
`define REG_LEVEL       32'h0000_000c

`define CTRL_SOFT_RST   0

`define ST_EMPTY_PIN    0
`define ST_FULL_PIN     1
`define ST_ALMOST_EMPTY 2
`define ST_HALF         3
`define ST_ALMOST_FULL  4
`define ST_FALL_THROUGH 5
`define ST_NINE_BIT     6

`define DATA_W          18
`define NARROW_W        9
`define DEPTH_WIDE      16'h2000
`define DEPTH_NARROW    16'h4000
`define MEM_WORDS       16'h4001
`define PTR_W           16
`define IDX_W           15

`define OFF_HLL         16'h03ff
`define OFF_LLH         16'h01ff
`define OFF_LHL         16'h00ff
`define OFF_LLL         16'h007f
`define OFF_LHH         16'h003f
`define OFF_HLH         16'h001f
`define OFF_HHL         16'h000f
`define OFF_HHH         16'h0007

`endif

// ---- design/fifo_flags_pkg.sv ----
/*
 * Types shared by the fifo flag block.
 * Assumes fifo_flags_params.svh is on the include path.
 */
`include "fifo_flags_params.svh"

package fifo_flags_pkg;
    typedef logic [`PTR_W-1:0]  ptr_t;
    typedef logic [`DATA_W-1:0] word_t;
endpackage : fifo_flags_pkg

// ---- design/fifo_flags.sv ----
/*
 * Dual-clock fifo with empty/output-ready, full/input-ready, half,
 * almost-empty and almost-full flags, standard or fall-through timing,
 * and an AHB-Lite slave for status and a soft master reset.
 * Assumes wclk and rclk are much slower than hclk (sampled, edge-detected);
 * pin inputs are asynchronous and pass two flip-flops before use.
 */
// Functional notes
// RULE1: strap at reset picks fall-through or standard
// RULE2: fall-through first word shows after three read edges
// RULE3: standard mode reader requests every word
// RULE4: write strobe low stores data each write edge
// RULE5: fall-through almost-empty high at n+2 words
// RULE6: fall-through half low at (D-1)/2+2 words
// RULE7: fall-through almost-full low at D-m words
// RULE8: fall-through capacity depth+1, input-ready blocks writes
// RULE9: fall-through input-ready clears two write edges after read
// RULE10: last read empties flag, reads ignored while empty
// RULE11: output-ready three stages, input-ready two stages
// RULE12: standard empty clears two read edges after write
// RULE13: standard almost-empty high at n+1 words
// RULE14: standard half low at D/2+1 words
// RULE15: standard almost-full low at D-m words
// RULE16: standard full low at D words, blocks writes
// RULE17: standard full clears two write edges after read
// RULE18: standard empty and full two register stages
// RULE19: nine-bit both sides doubles depth and thresholds
// RULE20: default offsets latched from load and select straps
// RULE21: pointers cross between read and write sides
`timescale 1ns/1ps
`include "fifo_flags_params.svh"

module fifo_flags (
    input  wire logic                hclk,
    input  wire logic                hresetn,
    input  wire logic                hsel,
    input  wire logic [31:0]         haddr,
    input  wire logic [1:0]          htrans,
    input  wire logic                hwrite,
    input  wire logic [2:0]          hsize,
    input  wire logic [31:0]         hwdata,
    input  wire logic                hready,
    output logic                     hreadyout,
    output logic                     hresp,
    output logic      [31:0]         hrdata,
    input  wire logic                wclk,
    input  wire logic                rclk,
    input  wire logic                wen_n,
    input  wire logic                ren_n,
    input  wire logic [`DATA_W-1:0]  din,
    input  wire logic                master_reset_n,
    input  wire logic                fall_through_select_serial_in,
    input  wire logic                offset_load_n,
    input  wire logic                default_offset_sel_0,
    input  wire logic                default_offset_sel_1,
    input  wire logic                nine_bit_mode,
    output logic      [`DATA_W-1:0]  output_bus,
    output logic                     empty_flag_n,
    output logic                     full_flag_n,
    output logic                     almost_empty_n,
    output logic                     half_level_n,
    output logic                     almost_full_n
);
    localparam int SW = 8 + `DATA_W;

    // pin synchronisers: stage one feeds only stage two
    logic [SW-1:0] pin_s1_q, pin_s2_q;
    logic          wclk_d_q, rclk_d_q;
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            pin_s1_q <= '0;
            pin_s2_q <= '0;
            wclk_d_q <= 1'b0;
            rclk_d_q <= 1'b0;
        end else begin
            pin_s1_q <= {wclk, rclk, wen_n, ren_n, master_reset_n,
                         fall_through_select_serial_in, offset_load_n,
                         default_offset_sel_0, default_offset_sel_1, din[`DATA_W-1:1]};
            pin_s2_q <= pin_s1_q;
            wclk_d_q <= pin_s2_q[SW-1];
            rclk_d_q <= pin_s2_q[SW-2];
        end
    end
    // nine-bit select rides a separate pair; din bit 0 rides a separate pair too
    logic nine_s1_q, nine_s2_q, d0_s1_q, d0_s2_q;
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            nine_s1_q <= 1'b0;
            nine_s2_q <= 1'b0;
            d0_s1_q   <= 1'b0;
            d0_s2_q   <= 1'b0;
        end else begin
            nine_s1_q <= nine_bit_mode;
            nine_s2_q <= nine_s1_q;
            d0_s1_q   <= din[0];
            d0_s2_q   <= d0_s1_q;
        end
    end

    logic                 wclk_s, rclk_s, wen_s, ren_s, mrs_pin_s;
    logic                 fts_s, ld_s, sel0_s, sel1_s;
    logic [`DATA_W-1:0]   din_s;
    logic                 wr_edge, rd_edge;
    assign {wclk_s, rclk_s, wen_s, ren_s, mrs_pin_s, fts_s, ld_s, sel0_s, sel1_s} =
           pin_s2_q[SW-1:SW-9];
    assign din_s   = {pin_s2_q[`DATA_W-2:0], d0_s2_q};
    assign wr_edge = wclk_s & ~wclk_d_q;
    assign rd_edge = rclk_s & ~rclk_d_q;

    // master reset: held from hresetn release until pin and soft request clear
    logic soft_rst_q, mrs_q;
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) mrs_q <= 1'b1;
        else          mrs_q <= ~mrs_pin_s | soft_rst_q;
    end

    // straps caught while master reset stands
    logic        fall_through_timing_q, nine_q;
    logic [15:0] offset_q;
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            fall_through_timing_q   <= 1'b0;
            nine_q   <= 1'b0;
            offset_q <= `OFF_LLL;
        end else if (mrs_q) begin
            fall_through_timing_q <= fts_s;                                   // [RULE1]
            nine_q <= nine_s2_q;                               // [RULE19]
            unique case ({ld_s, sel0_s, sel1_s})               // [RULE20]
                3'b100: offset_q <= `OFF_HLL;
                3'b001: offset_q <= `OFF_LLH;
                3'b010: offset_q <= `OFF_LHL;
                3'b000: offset_q <= `OFF_LLL;
                3'b011: offset_q <= `OFF_LHH;
                3'b101: offset_q <= `OFF_HLH;
                3'b110: offset_q <= `OFF_HHL;
                3'b111: offset_q <= `OFF_HHH;
            endcase
        end
    end

    // capacity and thresholds; nine-bit doubles the depth
    logic [15:0] depth, cap, half_thr, afull_thr, aempty_thr;
    assign depth      = nine_q ? `DEPTH_NARROW : `DEPTH_WIDE;              // [RULE19]
    assign cap        = fall_through_timing_q ? depth + 16'h0001 : depth;                 // [RULE8]
    assign half_thr   = fall_through_timing_q ? ((cap - 16'h0001) >> 1) + 16'h0002        // [RULE6]
                               : (depth >> 1) + 16'h0001;                  // [RULE14]
    assign afull_thr  = cap - offset_q;                                    // [RULE7] [RULE15]
    assign aempty_thr = offset_q + (fall_through_timing_q ? 16'h0002 : 16'h0001);         // [RULE5] [RULE13]

    // lap bit on top so pointers wrap at a non-power-of-two storage size
    function automatic fifo_flags_pkg::ptr_t ptr_inc(input fifo_flags_pkg::ptr_t p);
        if (p[`IDX_W-1:0] == `IDX_W'(`MEM_WORDS - 16'h0001))
            ptr_inc = {~p[`PTR_W-1], `IDX_W'h0};
        else
            ptr_inc = p + 16'h0001;
    endfunction : ptr_inc

    function automatic logic [15:0] level(input fifo_flags_pkg::ptr_t w,
                                          input fifo_flags_pkg::ptr_t r);
        if (w[`PTR_W-1] == r[`PTR_W-1])
            level = {1'b0, w[`IDX_W-1:0]} - {1'b0, r[`IDX_W-1:0]};
        else
            level = {1'b0, w[`IDX_W-1:0]} + `MEM_WORDS - {1'b0, r[`IDX_W-1:0]};
    endfunction : level

    fifo_flags_pkg::word_t mem [`MEM_WORDS];
    fifo_flags_pkg::ptr_t  wptr_q, rptr_q, cptr_q;
    fifo_flags_pkg::ptr_t  ws1_q, ws2_q, rs1_q;

    // write side: runs on write-clock edges
    logic                 full_flag_q, almost_full_q, half_q;
    logic                 wr_go;
    fifo_flags_pkg::ptr_t wptr_nx;
    logic [15:0]          wlvl_nx;
    // writes stop on the registered flag; rs1 lags so the flag is conservative
    assign wr_go   = !wen_s && (fall_through_timing_q ? !full_flag_q : full_flag_q);    // [RULE4] [RULE8] [RULE16]
    assign wptr_nx = wr_go ? ptr_inc(wptr_q) : wptr_q;
    assign wlvl_nx = level(wptr_nx, rs1_q);

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            wptr_q        <= '0;
            rs1_q         <= '0;
            full_flag_q   <= 1'b1;
            almost_full_q <= 1'b1;
            half_q        <= 1'b1;
        end else if (mrs_q) begin
            wptr_q        <= '0;
            rs1_q         <= '0;
            full_flag_q   <= ~fts_s;
            almost_full_q <= 1'b1;
            half_q        <= 1'b1;
        end else if (wr_edge) begin
            wptr_q        <= wptr_nx;
            rs1_q         <= cptr_q;                                       // [RULE21]
            // two stages: rs1 then flag, so a read shows after two write edges
            full_flag_q   <= fall_through_timing_q ? (wlvl_nx >= cap) : (wlvl_nx < cap);  // [RULE9] [RULE17] [RULE11] [RULE18]
            almost_full_q <= wlvl_nx < afull_thr;                          // [RULE7] [RULE15]
            half_q        <= wlvl_nx < half_thr;                           // [RULE6] [RULE14]
        end
    end

    always_ff @(posedge hclk) begin
        if (!mrs_q && wr_edge && wr_go)
            mem[wptr_q[`IDX_W-1:0]] <= nine_q ? {`NARROW_W'h0, din_s[`NARROW_W-1:0]}
                                              : din_s;                     // [RULE4]
    end

    // read side: runs on read-clock edges
    logic                 empty_flag_q, almost_empty_q;
    logic                 std_go, consume, avail, load;
    fifo_flags_pkg::ptr_t cptr_nx;
    assign std_go  = !fall_through_timing_q && !ren_s && empty_flag_q;                     // [RULE3] [RULE10]
    assign consume = fall_through_timing_q && !ren_s && !empty_flag_q;                     // [RULE10]
    assign avail   = ws2_q != rptr_q;
    assign load    = fall_through_timing_q && (empty_flag_q || consume) && avail;          // [RULE2]
    assign cptr_nx = (std_go || consume) ? ptr_inc(cptr_q) : cptr_q;

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            rptr_q         <= '0;
            cptr_q         <= '0;
            ws1_q          <= '0;
            ws2_q          <= '0;
            empty_flag_q   <= 1'b0;
            almost_empty_q <= 1'b0;
        end else if (mrs_q) begin
            rptr_q         <= '0;
            cptr_q         <= '0;
            ws1_q          <= '0;
            ws2_q          <= '0;
            empty_flag_q   <= fts_s;
            almost_empty_q <= 1'b0;
        end else if (rd_edge) begin
            ws1_q  <= wptr_q;                                               // [RULE21]
            ws2_q  <= ws1_q;
            cptr_q <= cptr_nx;
            if (std_go || load)
                rptr_q <= ptr_inc(rptr_q);
            if (fall_through_timing_q) begin
                // third stage: output register load drives output-ready
                if (load)
                    empty_flag_q <= 1'b0;                                   // [RULE2] [RULE11]
                else if (consume)
                    empty_flag_q <= 1'b1;                                   // [RULE10]
            end else begin
                empty_flag_q <= ws1_q != cptr_nx;                           // [RULE12] [RULE18]
            end
            almost_empty_q <= level(ws1_q, cptr_nx) >= aempty_thr;          // [RULE5] [RULE13]
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn)
            output_bus <= '0;
        else if (mrs_q)
            output_bus <= '0;
        else if (rd_edge && (std_go || load))
            output_bus <= mem[rptr_q[`IDX_W-1:0]];
    end

    assign empty_flag_n   = empty_flag_q;
    assign full_flag_n    = full_flag_q;
    assign almost_empty_n = almost_empty_q;
    assign half_level_n   = half_q;
    assign almost_full_n  = almost_full_q;

    // AHB-Lite slave: zero wait states, always OKAY
    logic        dp_wr_q;
    logic [31:0] dp_addr_q;
    logic        ap_take;
    logic [31:0] rd_mux;
    assign ap_take   = hsel && hready && htrans[1];
    assign hreadyout = 1'b1;
    assign hresp     = 1'b0;

    always_comb begin
        rd_mux = 32'h0;
        unique case (haddr)
            `REG_STATUS: begin
                rd_mux[`ST_EMPTY_PIN]    = empty_flag_q;
                rd_mux[`ST_FULL_PIN]     = full_flag_q;
                rd_mux[`ST_ALMOST_EMPTY] = almost_empty_q;
                rd_mux[`ST_HALF]         = half_q;
                rd_mux[`ST_ALMOST_FULL]  = almost_full_q;
                rd_mux[`ST_FALL_THROUGH] = fall_through_timing_q;
                rd_mux[`ST_NINE_BIT]     = nine_q;
            end
            `REG_OFFSETS: rd_mux = {offset_q, offset_q};
            `REG_LEVEL:   rd_mux = {16'h0, level(wptr_q, rs1_q)};
            default:      rd_mux = 32'h0;
        endcase
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            dp_wr_q   <= 1'b0;
            dp_addr_q <= 32'h0;
            hrdata    <= 32'h0;
        end else begin
            dp_wr_q <= ap_take && hwrite;
            if (ap_take) begin
                dp_addr_q <= haddr;
                hrdata    <= hwrite ? 32'h0 : rd_mux;
            end
        end
    end

    // soft reset is a one-cycle request; re-samples the straps like the pin
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn)
            soft_rst_q <= 1'b0;
        else
            soft_rst_q <= dp_wr_q && dp_addr_q == `REG_CONTROL && hwdata[`CTRL_SOFT_RST];
    end

    mode_latch_a: assert property (@(posedge hclk) disable iff (!hresetn) // [RULE1]
        mrs_q |=> fall_through_timing_q == $past(fts_s))
        else $error("timing mode not latched during master reset");

    write_store_a: assert property (@(posedge hclk) disable iff (!hresetn) // [RULE4]
        (!mrs_q && wr_edge && wr_go) |=> wptr_q == ptr_inc($past(wptr_q)))
        else $error("write strobe did not advance the write pointer");

    full_block_a: assert property (@(posedge hclk) disable iff (!hresetn) // [RULE16]
        (!fall_through_timing_q && !full_flag_q && !mrs_q) |=> wptr_q == $past(wptr_q))
        else $error("write accepted while full");

    empty_ignore_a: assert property (@(posedge hclk) disable iff (!hresetn) // [RULE10]
        (!fall_through_timing_q && !empty_flag_q && !mrs_q) |=> cptr_q == $past(cptr_q))
        else $error("read accepted while empty");

    half_track_a: assert property (@(posedge hclk) disable iff (!hresetn) // [RULE14] [RULE6]
        (!mrs_q && wr_edge) |=> half_q == ($past(wlvl_nx) <
            ((nine_q ? `DEPTH_NARROW : `DEPTH_WIDE) >> 1) + 16'h0001 + {15'h0, fall_through_timing_q}))
        else $error("half flag disagrees with level");

    afull_track_a: assert property (@(posedge hclk) disable iff (!hresetn) // [RULE15] [RULE7]
        (!mrs_q && wr_edge) |=> almost_full_q == ($past(wlvl_nx) <
            (nine_q ? `DEPTH_NARROW : `DEPTH_WIDE) + {15'h0, fall_through_timing_q} - offset_q))
        else $error("almost-full flag disagrees with level");

    aempty_track_a: assert property (@(posedge hclk) disable iff (!hresetn) // [RULE13] [RULE5]
        (!mrs_q && rd_edge) |=> almost_empty_q ==
            (level($past(ws1_q), $past(cptr_nx)) >= offset_q + 16'h0001 + {15'h0, fall_through_timing_q}))
        else $error("almost-empty flag disagrees with level");

    ft_load_a: assert property (@(posedge hclk) disable iff (!hresetn) // [RULE2]
        (!mrs_q && rd_edge && fall_through_timing_q && empty_flag_q && avail) |=> !empty_flag_q)
        else $error("fall-through word not presented");

    ir_block_a: assert property (@(posedge hclk) disable iff (!hresetn) // [RULE8]
        (fall_through_timing_q && full_flag_q && !mrs_q) |=> wptr_q == $past(wptr_q))
        else $error("write accepted while input not ready");

    ft_ignore_a: assert property (@(posedge hclk) disable iff (!hresetn) // [RULE10]
        (fall_through_timing_q && empty_flag_q && !mrs_q) |=> cptr_q == $past(cptr_q))
        else $error("fall-through read accepted while empty");

    std_hold_a: assert property (@(posedge hclk) disable iff (!hresetn) // [RULE3]
        (!fall_through_timing_q && !mrs_q && rd_edge && ren_s) |=> $stable(output_bus))
        else $error("standard output changed without a read strobe");

    full_clock_a: assert property (@(posedge hclk) disable iff (!hresetn) // [RULE21]
        $changed(full_flag_q) |-> $past(wr_edge) || $past(mrs_q))
        else $error("full-side flag moved off a write-clock edge");

    empty_clock_a: assert property (@(posedge hclk) disable iff (!hresetn) // [RULE21]
        $changed(empty_flag_q) |-> $past(rd_edge) || $past(mrs_q))
        else $error("empty-side flag moved off a read-clock edge");

    offset_pick_a: assert property (@(posedge hclk) disable iff (!hresetn) // [RULE20]
        (mrs_q && ld_s && !sel0_s && !sel1_s) |=> offset_q == `OFF_HLL)
        else $error("default offset not latched from straps");

endmodule : fifo_flags

// ---- sim/fifo_peer.sv ----
/* Far-side writer and reader of the fifo: makes wclk and rclk only inside
   transfers, drives strobes and write data.
   Assumes the bench calls its tasks from one process at a time. */
`timescale 1ns/1ps
module fifo_peer (
    output logic                  wclk,
    output logic                  rclk,
    output logic                  wen_n,
    output logic                  ren_n,
    output fifo_flags_pkg::word_t din
);
    initial begin
        wclk = 1'b0;
        rclk = 1'b0;
        wen_n = 1'b1;
        ren_n = 1'b1;
        din = '0;
    end

    // one 160 ns write-clock period; edge kept off the hclk grid
    task automatic pulse_w(input logic we, input fifo_flags_pkg::word_t d);
        wen_n = !we;
        din = d;
        #47 wclk = 1'b1;
        #80 wclk = 1'b0;
        wen_n = 1'b1;
        // released data no longer shows the last word
        din = ~d;
        #33;
    endtask : pulse_w

    task automatic pulse_r(input logic re);
        ren_n = !re;
        #47 rclk = 1'b1;
        #80 rclk = 1'b0;
        ren_n = 1'b1;
        #33;
    endtask : pulse_r
endmodule : fifo_peer

// ---- sim/tb_fifo_flags.sv ----
/* Self-checking bench of the fifo flag block: AHB-Lite register access,
   fall-through and standard timing, and one full standard fill.
   Assumes the smallest default offset and 18-bit words until the closing
   sweep, which re-latches every offset strap code by soft reset. */
`timescale 1ns/1ps
module tb_fifo_flags;
    localparam int N_OFF = 7;
    localparam int M_OFF = 7;
    localparam int DEPTH = 8192;
    logic                  hclk, hresetn, hsel, hwrite, hreadyout, hresp;
    logic [31:0]           haddr, hwdata, hrdata, rd;
    logic [1:0]            htrans;
    logic [2:0]            hsize;
    logic                  wclk, rclk, wen_n, ren_n, master_reset_n;
    fifo_flags_pkg::word_t din, output_bus;
    logic                  ft_sel, ld_n, sel0, sel1, nine_bit;
    logic                  empty_flag_n, full_flag_n, almost_empty_n;
    logic                  half_level_n, almost_full_n;
    int                    failures = 0;
    int                    cmp_count = 0;
    logic [15:0]           off_tab [8] = '{16'h007f, 16'h01ff, 16'h00ff, 16'h003f,
                                           16'h03ff, 16'h001f, 16'h000f, 16'h0007};

    fifo_flags fifo_flags_i (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
        .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
        .hready(hreadyout), .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata),
        .wclk(wclk), .rclk(rclk), .wen_n(wen_n), .ren_n(ren_n), .din(din),
        .master_reset_n(master_reset_n), .fall_through_select_serial_in(ft_sel),
        .offset_load_n(ld_n), .default_offset_sel_0(sel0), .default_offset_sel_1(sel1),
        .nine_bit_mode(nine_bit), .output_bus(output_bus), .empty_flag_n(empty_flag_n),
        .full_flag_n(full_flag_n), .almost_empty_n(almost_empty_n),
        .half_level_n(half_level_n), .almost_full_n(almost_full_n));
    fifo_peer fifo_peer_i (.wclk(wclk), .rclk(rclk), .wen_n(wen_n), .ren_n(ren_n),
        .din(din));

    always #10 hclk = ~hclk;

    task automatic check_flag(input string nm, input logic e, input logic g);
        cmp_count++;
        if (g !== e) begin
            failures++;
            $display("mismatch %s expected %b seen %b", nm, e, g);
        end
    endtask : check_flag

    task automatic check_word(input string nm, input logic [31:0] e, input logic [31:0] g);
        cmp_count++;
        if (g !== e) begin
            failures++;
            $display("mismatch %s expected %h seen %h", nm, e, g);
        end
    endtask : check_word

    task automatic bus(input logic wr, input logic [31:0] a, input logic [31:0] wd);
        @(posedge hclk);
        hsel <= 1'b1;
        htrans <= 2'b10;
        haddr <= a;
        hwrite <= wr;
        hsize <= 3'b010;
        do @(posedge hclk); while (hreadyout !== 1'b1);
        hsel <= 1'b0;
        htrans <= 2'b00;
        hwdata <= wd;
        do @(posedge hclk); while (hreadyout !== 1'b1);
        rd = hrdata;
    endtask : bus

    // idle edges on both link clocks let synchronised pointers land
    task automatic settle();
        repeat (3) fifo_peer_i.pulse_w(1'b0, '0);
        repeat (3) fifo_peer_i.pulse_r(1'b0);
    endtask : settle

    task automatic std_levels(input int i);
        settle();
        check_flag("almost_empty_n", i >= N_OFF + 1, almost_empty_n);
        check_flag("half_level_n", i < DEPTH / 2 + 1, half_level_n);
        check_flag("almost_full_n", i < DEPTH - M_OFF, almost_full_n);
        check_flag("full_flag_n", i < DEPTH, full_flag_n);
    endtask : std_levels

    task automatic stop_test();
        if (failures == 0 && cmp_count > 0) $display("Result: passed");
        else $display("Result: failed");
        $finish;
    endtask : stop_test

    initial begin
        repeat (95000) @(posedge hclk);
        failures++;
        stop_test();
    end

    initial begin
        hclk = 1'b0;
        hresetn = 1'b0;
        {hsel, hwrite, htrans, haddr, hwdata, hsize} = '0;
        master_reset_n = 1'b0;
        {ft_sel, ld_n, sel0, sel1, nine_bit} = 5'b11110;
        repeat (20) @(posedge hclk);
        hresetn <= 1'b1;
        repeat (4) @(posedge hclk);
        master_reset_n <= 1'b1;
        repeat (6) @(posedge hclk);
        bus(1'b0, 32'h0000_0000, '0);
        check_word("status mode", 32'h0000_0020, rd & 32'h0000_0060);
        bus(1'b0, 32'h0000_0008, '0);
        check_word("offsets", 32'h0007_0007, rd);
        bus(1'b0, 32'h0000_0010, '0);
        check_word("unmapped", 32'h0000_0000, rd);
        check_flag("hresp", 1'b0, hresp);
        check_flag("empty_flag_n", 1'b1, empty_flag_n);
        check_flag("full_flag_n", 1'b0, full_flag_n);
        fifo_peer_i.pulse_w(1'b1, 18'h2a5a5);
        repeat (2) fifo_peer_i.pulse_r(1'b0);
        check_flag("empty_flag_n", 1'b1, empty_flag_n);
        fifo_peer_i.pulse_r(1'b0);
        check_flag("empty_flag_n", 1'b0, empty_flag_n);
        check_word("output_bus", 32'h0002_a5a5, {14'h0, output_bus});
        for (int i = 2; i <= N_OFF + 1; i++) fifo_peer_i.pulse_w(1'b1, 18'(i));
        settle();
        check_flag("almost_empty_n", 1'b0, almost_empty_n);
        fifo_peer_i.pulse_w(1'b1, 18'h00009);
        settle();
        check_flag("almost_empty_n", 1'b1, almost_empty_n);
        fifo_peer_i.pulse_r(1'b1);
        settle();
        check_flag("almost_empty_n", 1'b0, almost_empty_n);
        // one read more than stored: the last is ignored
        repeat (N_OFF + 2) fifo_peer_i.pulse_r(1'b1);
        settle();
        check_flag("empty_flag_n", 1'b1, empty_flag_n);
        bus(1'b0, 32'h0000_000c, '0);
        check_word("level", 32'h0000_0000, rd);
        ft_sel <= 1'b0;
        bus(1'b1, 32'h0000_0004, 32'h0000_0001);
        repeat (10) @(posedge hclk);
        bus(1'b0, 32'h0000_0000, '0);
        check_word("status mode", 32'h0000_0000, rd & 32'h0000_0060);
        check_flag("empty_flag_n", 1'b0, empty_flag_n);
        check_flag("full_flag_n", 1'b1, full_flag_n);
        fifo_peer_i.pulse_w(1'b1, 18'h1c3c3);
        fifo_peer_i.pulse_r(1'b0);
        check_flag("empty_flag_n", 1'b0, empty_flag_n);
        fifo_peer_i.pulse_r(1'b0);
        check_flag("empty_flag_n", 1'b1, empty_flag_n);
        fifo_peer_i.pulse_r(1'b1);
        check_word("output_bus", 32'h0001_c3c3, {14'h0, output_bus});
        repeat (2) fifo_peer_i.pulse_r(1'b0);
        check_flag("empty_flag_n", 1'b0, empty_flag_n);
        fifo_peer_i.pulse_r(1'b1);
        check_word("output_bus", 32'h0001_c3c3, {14'h0, output_bus});
        for (int i = 1; i <= DEPTH; i++) begin
            fifo_peer_i.pulse_w(1'b1, 18'h15555 ^ 18'(i - 1));
            if (i inside {N_OFF, N_OFF + 1, DEPTH / 2, DEPTH / 2 + 1, DEPTH - M_OFF - 1,
                          DEPTH - M_OFF, DEPTH - 1, DEPTH}) std_levels(i);
        end
        fifo_peer_i.pulse_w(1'b1, 18'h3ffff);
        settle();
        bus(1'b0, 32'h0000_000c, '0);
        check_word("level", 32'h0000_2000, rd);
        fifo_peer_i.pulse_r(1'b1);
        check_word("output_bus", 32'h0001_5555, {14'h0, output_bus});
        fifo_peer_i.pulse_w(1'b0, '0);
        check_flag("full_flag_n", 1'b0, full_flag_n);
        fifo_peer_i.pulse_w(1'b0, '0);
        check_flag("full_flag_n", 1'b1, full_flag_n);
        // every offset strap code, with mode and width toggled alongside
        for (int k = 0; k < 8; k++) begin
            {ld_n, sel0, sel1} <= 3'(k);
            ft_sel <= k[1];
            nine_bit <= k[0];
            bus(1'b1, 32'h0000_0004, 32'h0000_0001);
            repeat (10) @(posedge hclk);
            bus(1'b0, 32'h0000_0008, '0);
            check_word("offsets", {off_tab[k], off_tab[k]}, rd);
            bus(1'b0, 32'h0000_0000, '0);
            check_word("status mode", {25'h0, k[0], k[1], 5'h0}, rd & 32'h0000_0060);
            check_flag("empty_flag_n", k[1], empty_flag_n);
            check_flag("full_flag_n", !k[1], full_flag_n);
        end
        // last code: fall-through, nine-bit; only the low nine bits are kept
        fifo_peer_i.pulse_w(1'b1, 18'h3fe5a);
        repeat (3) fifo_peer_i.pulse_r(1'b0);
        check_word("output_bus", 32'h0000_005a, {14'h0, output_bus});
        stop_test();
    end
endmodule : tb_fifo_flags
